// ### rtl/pso_pkg.sv
// Package for the output phase-shift control block.
// Assumes a 200 MHz aclk and an AXI4-Lite register master.
package pso_pkg;
  // ----------------------------------------------------------------------
  // Register map (printed offsets are not word aligned, so they are indices)
  // ----------------------------------------------------------------------
  localparam logic [7:0] HIGH_CTRL_IDX = 8'h06;
  localparam logic [7:0] LOW_WORD_IDX = 8'h07;
  localparam logic [11:0] HIGH_CTRL_ADDR = {2'h0, HIGH_CTRL_IDX, 2'h0};
  localparam logic [11:0] LOW_WORD_ADDR = {2'h0, LOW_WORD_IDX, 2'h0};
  // Field positions
  localparam int ENABLE_BIT = 3;
  localparam int UPPER_MSB = 2;
  // Reset values
  localparam logic [7:0] HIGH_CTRL_RST = 8'h00;
  localparam logic [7:0] LOW_WORD_RST = 8'h00;
  localparam logic [10:0] WORD_MAX = 11'h7ff;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam real CLK_PERIOD_NS = 5.0;
  localparam real STEP_NS = 61.035;
  // Cycles per offset step, rounded down to whole cycles (no lower clamp)
  localparam int STEP_CYCLES = int'(STEP_NS / CLK_PERIOD_NS - 0.5);
  localparam logic [3:0] STEP_CNT = 4'(STEP_CYCLES);
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Applied shift as carried to the clock generator
  typedef struct packed {
    logic enable;
    logic [10:0] word;
  } pso_shift_s;

  typedef enum logic [1:0] {
    SH_IDLE,
    SH_ADVANCE,
    SH_DELAY
  } pso_shift_e;
endpackage

// ### rtl/pso_top.sv
// Output phase-shift control: registers plus applied shift tracking.
// Assumes the clock generator consumes the applied shift and a
// per-cycle advance/delay request, and an AXI4-Lite master.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module pso_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Shift to the 16 MHz-derived clock and frame generator
  output logic shift_enable,
  output logic [10:0] shift_word,
  output logic shift_advance,
  output logic shift_delay,
  output logic shift_busy
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [7:0] high_r, high_nxt;
  logic [7:0] low_r, low_nxt;
  logic [11:0] awaddr_r, awaddr_nxt;
  logic aw_have_r, aw_have_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic w_have_r, w_have_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wr_fire;

  // Address decode, used by both the write and the read path
  function automatic logic [1:0] decode(input logic [11:0] a);
    if (a == pso_pkg::HIGH_CTRL_ADDR) begin
      decode = 2'h1;
    end else if (a == pso_pkg::LOW_WORD_ADDR) begin
      decode = 2'h2;
    end else begin
      decode = 2'h0;
    end
  endfunction

  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready = !w_have_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign wr_fire = aw_have_r && w_have_r;

  // Write channel capture; address and data may come in either order
  always_comb begin
    awaddr_nxt = awaddr_r;
    aw_have_nxt = aw_have_r;
    wdata_nxt = wdata_r;
    w_have_nxt = w_have_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    high_nxt = high_r;
    low_nxt = low_r;
    if (s_axi_awvalid && s_axi_awready) begin
      awaddr_nxt = s_axi_awaddr;
      aw_have_nxt = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wdata_nxt = {s_axi_wstrb[0] ? 24'h000001 : 24'h000000,
                   s_axi_wdata[7:0]};
      w_have_nxt = 1'b1;
    end
    if (wr_fire) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = pso_pkg::RESP_OKAY;
      // Only byte lane 0 carries the 8-bit registers
      if (decode(awaddr_r) == 2'h1) begin
        if (wdata_r[8]) begin
          high_nxt = {4'h0, wdata_r[3:0]};
        end
      end else if (decode(awaddr_r) == 2'h2) begin
        if (wdata_r[8]) begin
          low_nxt = wdata_r[7:0];
        end
      end else begin
        bresp_nxt = pso_pkg::RESP_SLVERR;
      end
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  // Read channel; one cycle from address to data
  always_comb begin
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = pso_pkg::RESP_OKAY;
      if (decode(s_axi_araddr) == 2'h1) begin
        rdata_nxt = {24'h000000, high_r};
      end else if (decode(s_axi_araddr) == 2'h2) begin
        rdata_nxt = {24'h000000, low_r};
      end else begin
        rdata_nxt = 32'h00000000;
        rresp_nxt = pso_pkg::RESP_SLVERR;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // Bus and register flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_r <= pso_pkg::HIGH_CTRL_RST;
      low_r <= pso_pkg::LOW_WORD_RST;
      awaddr_r <= 12'h000;
      aw_have_r <= 1'b0;
      wdata_r <= 32'h00000000;
      w_have_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rresp_r <= 2'h0;
      rdata_r <= 32'h00000000;
    end else begin
      high_r <= high_nxt;
      low_r <= low_nxt;
      awaddr_r <= awaddr_nxt;
      aw_have_r <= aw_have_nxt;
      wdata_r <= wdata_nxt;
      w_have_r <= w_have_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Applied shift tracking
  // ----------------------------------------------------------------------
  // The applied word walks toward the programmed target one step at a
  // time, so a careless multi-step write still moves the clocks gently.
  logic [10:0] target;
  logic enable_req;
  pso_pkg::pso_shift_s applied_r, applied_nxt;
  pso_pkg::pso_shift_e state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic adv_r, adv_nxt;
  logic dly_r, dly_nxt;

  assign target = {high_r[pso_pkg::UPPER_MSB:0], low_r};
  assign enable_req = high_r[pso_pkg::ENABLE_BIT];

  // Step engine: one applied step per step time, relied upon
  always_comb begin
    applied_nxt = applied_r;
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    adv_nxt = 1'b0;
    dly_nxt = 1'b0;
    applied_nxt.enable = enable_req;
    case (state_r)
      // The idle cycle is part of the step, so count one fewer
      pso_pkg::SH_IDLE: begin
        if (target > applied_r.word) begin
          state_nxt = pso_pkg::SH_ADVANCE;
          cnt_nxt = pso_pkg::STEP_CNT - 4'h1;
        end else if (target < applied_r.word) begin
          state_nxt = pso_pkg::SH_DELAY;
          cnt_nxt = pso_pkg::STEP_CNT - 4'h1;
        end
      end
      pso_pkg::SH_ADVANCE: begin
        if (cnt_r == 4'h1) begin
          applied_nxt.word = applied_r.word + 11'h001;
          adv_nxt = enable_req;
          state_nxt = pso_pkg::SH_IDLE;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      pso_pkg::SH_DELAY: begin
        if (cnt_r == 4'h1) begin
          applied_nxt.word = applied_r.word - 11'h001;
          dly_nxt = enable_req;
          state_nxt = pso_pkg::SH_IDLE;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      default: begin
        state_nxt = pso_pkg::SH_IDLE;
      end
    endcase
  end

  // Step engine flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      applied_r <= '0;
      state_r <= pso_pkg::SH_IDLE;
      cnt_r <= 4'h0;
      adv_r <= 1'b0;
      dly_r <= 1'b0;
    end else begin
      applied_r <= applied_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      adv_r <= adv_nxt;
      dly_r <= dly_nxt;
    end
  end

  // Disabled shift shows as zero to every derived clock and frame
  assign shift_enable = applied_r.enable;
  assign shift_word = applied_r.enable ? applied_r.word : 11'h000;
  assign shift_advance = adv_r;
  assign shift_delay = dly_r;
  assign shift_busy = state_r != pso_pkg::SH_IDLE;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Busy run length, counted here so a long run needs no repetition
  logic [3:0] busy_len_r, busy_len_nxt;

  // Counts busy cycles back to back; idle clears it
  always_comb begin
    busy_len_nxt = 4'h0;
    if (shift_busy) begin
      busy_len_nxt = busy_len_r + 4'h1;
    end
  end

  // Busy run flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_len_r <= 4'h0;
    end else begin
      busy_len_r <= busy_len_nxt;
    end
  end

  // One step ends when busy drops
  sequence step_end_s;
    $fell(shift_busy);
  endsequence

  // A step pulse of either direction
  sequence step_pulse_s;
    shift_advance || shift_delay;
  endsequence

  // Settled: idle now and one cycle back, target unchanged
  sequence settled_s;
    !shift_busy && !$past(shift_busy) && $stable(target);
  endsequence

  enable_gate_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !shift_enable |-> shift_word == 11'h000 &&
    !shift_advance && !shift_delay)
    else $error("shift seen while disabled");
  enable_follow_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    1'b1 |=> shift_enable == $past(high_r[pso_pkg::ENABLE_BIT]))
    else $error("enable does not follow control bit");
  word_form_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    settled_s |-> applied_r.word == {high_r[2:0], low_r})
    else $error("applied word does not reach target");
  word_range_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    shift_advance |-> applied_r.word != 11'h000)
    else $error("applied word wrapped upward");
  word_floor_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    shift_delay |-> applied_r.word != pso_pkg::WORD_MAX)
    else $error("applied word wrapped downward");
  step_time_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    step_end_s |-> busy_len_r == pso_pkg::STEP_CNT - 4'h1)
    else $error("step time wrong");
  step_bound_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    shift_busy |-> busy_len_r < pso_pkg::STEP_CNT - 4'h1)
    else $error("step engine busy too long");
  pulse_idle_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    step_pulse_s |-> !shift_busy)
    else $error("step pulse while still counting");
  advance_up_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    shift_advance |-> applied_r.word == $past(applied_r.word) + 11'h001)
    else $error("advance without word increase");
  delay_down_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    shift_delay |-> applied_r.word == $past(applied_r.word) - 11'h001)
    else $error("delay without word decrease");
  reserved_zero_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    high_r[7:4] == 4'h0)
    else $error("reserved bits not zero");
  reset_clear_a: assert property (
    @(posedge aclk)
    !aresetn |=> applied_r.word == 11'h000 && !shift_enable)
    else $error("reset did not clear shift");
endmodule

// ### testbench/pso_top_test.sv
// Self-checking bench for the output phase-shift control block.
// Assumes pso_top and pso_pkg are compiled first; drives AXI4-Lite itself.
`timescale 1ns/1ps
module pso_top_test;
  // ----------------------------------------------------------------------
  // Signals and instance
  // ----------------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, shift_enable, shift_advance, shift_delay, shift_busy;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [10:0] shift_word;
  int errors = 0;
  int checks_done = 0;
  int c;
  logic [1:0] r;
  logic [31:0] d;

  pso_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .shift_enable,
    .shift_word, .shift_advance, .shift_delay, .shift_busy);

  // 200 MHz clock
  always #2.5 aclk = ~aclk;

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  // Compare and count; four-state so an unknown never matches
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task finish_test;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Handshakes judged at the falling edge, taken at the next rising one
  task axi_wr(input logic [11:0] a, input logic [7:0] v, input logic [3:0] s,
              output logic [1:0] rsp);
    logic ag, wg, bg;
    int n;
    n = 0;
    bg = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, v};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!bg && n < 50) begin
      @(negedge aclk);
      ag = s_axi_awvalid && s_axi_awready;
      wg = s_axi_wvalid && s_axi_wready;
      bg = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (ag) s_axi_awvalid <= 1'b0;
      if (wg) s_axi_wvalid <= 1'b0;
      n++;
    end
    s_axi_bready <= 1'b0;
    if (!bg) errors++;
  endtask

  task axi_rd(input logic [11:0] a, output logic [31:0] v,
              output logic [1:0] rsp);
    logic ag, rg;
    int n;
    n = 0;
    rg = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rg && n < 50) begin
      @(negedge aclk);
      ag = s_axi_arvalid && s_axi_arready;
      rg = s_axi_rvalid;
      v = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ag) s_axi_arvalid <= 1'b0;
      n++;
    end
    s_axi_rready <= 1'b0;
    if (!rg) errors++;
  endtask

  // Cycles until the next one-cycle step pulse, bounded
  task step_wait(output int n);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (!(shift_advance || shift_delay) && n < 100);
  endtask

  // A long walk takes 12 cycles a step, so the bound is generous
  task word_wait(input logic [10:0] w, input int lim);
    int n;
    n = 0;
    while (shift_word !== w && n < lim) begin
      @(negedge aclk);
      n++;
    end
  endtask

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check({shift_enable, shift_busy, shift_word}, 32'h0);
    axi_rd(pso_pkg::HIGH_CTRL_ADDR, d, r);
    check(d, 32'h0);
    axi_rd(pso_pkg::LOW_WORD_ADDR, d, r);
    check(d, 32'h0);
    // Reserved bits dropped, enable reaches the outputs
    axi_wr(pso_pkg::HIGH_CTRL_ADDR, 8'hf8, 4'h1, r);
    check(r, pso_pkg::RESP_OKAY);
    axi_rd(pso_pkg::HIGH_CTRL_ADDR, d, r);
    check(d, 32'h08);
    check(shift_enable, 1'b1);
    // Single steps up
    axi_wr(pso_pkg::LOW_WORD_ADDR, 8'h01, 4'h1, r);
    step_wait(c);
    check({shift_advance, shift_delay, shift_word}, 32'h1001);
    axi_wr(pso_pkg::LOW_WORD_ADDR, 8'h02, 4'h1, r);
    step_wait(c);
    check(shift_word, 32'h002);
    // Upper bits: long walk, step spacing measured mid-walk
    axi_wr(pso_pkg::HIGH_CTRL_ADDR, 8'h09, 4'h1, r);
    @(negedge aclk);
    check(shift_busy, 1'b1);
    step_wait(c);
    step_wait(c);
    check(c, pso_pkg::STEP_CYCLES);
    word_wait(11'h102, 4000);
    check(shift_word, 32'h102);
    // Going down delays the outputs
    axi_wr(pso_pkg::LOW_WORD_ADDR, 8'h01, 4'h1, r);
    step_wait(c);
    check({shift_advance, shift_delay, shift_word}, 32'h0101 | 32'h800);
    // Top of the range
    axi_wr(pso_pkg::HIGH_CTRL_ADDR, 8'h0f, 4'h1, r);
    axi_wr(pso_pkg::LOW_WORD_ADDR, 8'hff, 4'h1, r);
    word_wait(pso_pkg::WORD_MAX, 25000);
    check(shift_word, 32'h7ff);
    // Disabled: no offset and no pulses
    axi_wr(pso_pkg::HIGH_CTRL_ADDR, 8'h07, 4'h1, r);
    @(negedge aclk);
    check({shift_enable, shift_word}, 32'h0);
    axi_wr(pso_pkg::LOW_WORD_ADDR, 8'hfe, 4'h1, r);
    step_wait(c);
    check(c, 100);
    // Unmapped place and a write outside byte lane 0
    axi_rd(12'h000, d, r);
    check(r, pso_pkg::RESP_SLVERR);
    check(d, 32'h0);
    axi_wr(12'h000, 8'h5a, 4'h1, r);
    check(r, pso_pkg::RESP_SLVERR);
    axi_wr(pso_pkg::LOW_WORD_ADDR, 8'h55, 4'h2, r);
    axi_rd(pso_pkg::LOW_WORD_ADDR, d, r);
    check(r, pso_pkg::RESP_OKAY);
    check(d, 32'hfe);
    finish_test();
  end

  // Watchdog well beyond the longest walk
  initial begin
    #(60000 * 5);
    errors++;
    finish_test();
  end
endmodule
